// ==== verilog/wpq_status_query.v ====
`timescale 1ns/100ps
`default_nettype none
`include "wpq_map.vh"

module wpq_status_query (
   input  wire       clk_sys,
   input  wire       reset,
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_oe_n,
   input  wire       chip_select_pin_0,
   input  wire       chip_select_pin_1,
   input  wire       chip_select_pin_2,
   input  wire       permanent_protect_flag,
   input  wire       reversible_protect_flag,
   output reg        lower_half_protect,
   output reg        lower_half_reversible
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_IDLE  = 4'b0001;
   localparam ST_SHIFT = 4'b0010;
   localparam ST_ACK   = 4'b0100;
   localparam ST_WAIT  = 4'b1000;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   wire [6:0] pins_sync;
   wpq_sync #(
      .WIDTH (7)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .pin_in   ({scl_in, sda_in, chip_select_pin_2, chip_select_pin_1,
                  chip_select_pin_0, permanent_protect_flag, reversible_protect_flag}),
      .pin_sync (pins_sync)
   );
   wire scl    = pins_sync[6];
   wire sda    = pins_sync[5];
   wire [2:0] sel = pins_sync[4:2];
   wire pflag  = pins_sync[1];
   wire rflag  = pins_sync[0];

   // ----------------------------------------
   // Registers and next values
   // ----------------------------------------
   // Registered state
   reg        scl_d;
   reg        sda_d;
   reg  [3:0] state;
   reg  [3:0] bit_cnt;
   reg  [7:0] shreg;
   reg        ack_on;
   reg  [1:0] settle_cnt;
   // Next values
   reg  [3:0] next_state;
   reg  [3:0] next_bit_cnt;
   reg  [7:0] next_shreg;
   reg        next_ack_on;
   reg        next_sda_oe_n;
   reg        next_protect;
   reg        next_reversible;
   // Synchroniser output real once this is set
   wire       settled = (settle_cnt == `WPQ_SETTLE_COUNT);

   // ----------------------------------------
   // Bus conditions
   // ----------------------------------------
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_c  = scl & scl_d & sda_d & ~sda;
   wire stop_c   = scl & scl_d & ~sda_d & sda;

   // ----------------------------------------
   // Query byte decode
   // ----------------------------------------
   // Byte as completed by this rising edge
   wire [7:0] byte_now = {shreg[6:0], sda};
   wire pre_ok   = byte_now[`WPQ_PRE_MSB:`WPQ_PRE_LSB] == `WPQ_PREAMBLE;
   wire rd_ok    = byte_now[`WPQ_RW_BIT] == `WPQ_READ_BIT;
   wire [2:0] sel_byte = byte_now[`WPQ_SEL_MSB:`WPQ_SEL_LSB];
   // Permanent query addresses this device's own select levels
   wire hit_perm = pre_ok & rd_ok & (sel_byte == sel);
   // Reversible query needs select pins 2 and 1 low
   wire hit_rev  = pre_ok & rd_ok & (sel_byte == `WPQ_REVERSIBLE_PROTECT_FLAG_SELECT)
                   & ~sel[2] & ~sel[1];
   // Acknowledge only while the chosen flag is clear
   wire next_ack = (hit_perm & ~pflag) | (hit_rev & ~rflag & ~hit_perm);

   // ----------------------------------------
   // Edge history
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // ----------------------------------------
   // Synchroniser settle count
   // ----------------------------------------
   // Synchronisers leave reset at ones; count two edges before trusting them
   always @(posedge clk_sys) begin
      if (reset) begin
         settle_cnt <= 2'h0;
      end else if (!settled) begin
         settle_cnt <= settle_cnt + 2'h1;
      end
   end

   // ----------------------------------------
   // Query state machine
   // ----------------------------------------
   // Next state, bit count, shift and line enable
   always @* begin
      // Hold everything unless an event moves it
      next_state    = state;
      next_bit_cnt  = bit_cnt;
      next_shreg    = shreg;
      next_ack_on   = ack_on;
      next_sda_oe_n = sda_oe_n;
      if (start_c) begin
         // Any start opens a fresh byte
         next_state    = ST_SHIFT;
         next_bit_cnt  = 4'h0;
         next_sda_oe_n = 1'b1;
      end else if (stop_c) begin
         // Stop abandons whatever was under way
         next_state    = ST_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (state)
            ST_SHIFT: begin
               // One bit per bus clock rise, msb first
               if (scl_rise) begin
                  next_shreg   = byte_now;
                  next_bit_cnt = bit_cnt + 4'h1;
                  if (bit_cnt == `WPQ_BIT_COUNT - 4'h1) begin
                     next_ack_on = next_ack;
                     next_state  = ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               // Drive low through the ninth clock when ack_on is set
               if (scl_fall) begin
                  next_sda_oe_n = ~ack_on;
                  next_state    = ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Release after ninth clock; no data follows
               if (scl_fall) begin
                  next_sda_oe_n = 1'b1;
                  next_state    = ST_IDLE;
               end
            end
            ST_IDLE: begin
               // Line stays released between queries
               next_sda_oe_n = 1'b1;
            end
            default: begin
               // Unused codes fall back to idle
               next_state    = ST_IDLE;
               next_sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Query state registers
   // ----------------------------------------
   // All state moves on every edge
   always @(posedge clk_sys) begin
      if (reset) begin
         state    <= ST_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         ack_on   <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         state    <= next_state;
         bit_cnt  <= next_bit_cnt;
         shreg    <= next_shreg;
         ack_on   <= next_ack_on;
         sda_oe_n <= next_sda_oe_n;
      end
   end

   // ----------------------------------------
   // Lower-half protection status
   // ----------------------------------------
   // Frozen while synchronisers settle, so no false protect after reset
   always @* begin
      next_protect    = lower_half_protect;
      next_reversible = lower_half_reversible;
      if (settled) begin
         next_protect    = pflag | rflag;
         next_reversible = rflag & ~pflag;
      end
   end

   // Status outputs straight from flip-flops
   always @(posedge clk_sys) begin
      if (reset) begin
         lower_half_protect    <= 1'b0;
         lower_half_reversible <= 1'b0;
      end else begin
         lower_half_protect    <= next_protect;
         lower_half_reversible <= next_reversible;
      end
   end

endmodule

`default_nettype wire

// ==== verilog/wpq_map.vh ====
// Operation
// - On a permanent-flag query the device acknowledges only while the permanent flag is clear.
// - A reversible-flag query is acknowledged only while the reversible flag is clear, or with select pin 0 high only while the permanent flag is clear.
// - A set reversible flag write-protects the lower half reversibly only while the permanent flag is clear.
// - Permanent query byte is 0110, then the three chip select pin levels, then a one.
// - Reversible query byte is 0110, 001, then a one, and applies only with select pins 2 and 1 low.
`ifndef WPQ_MAP_VH
`define WPQ_MAP_VH

// ----------------------------------------
// Query byte fields, bit count and settle count
// ----------------------------------------
`define WPQ_PREAMBLE      4'h6
`define WPQ_REVERSIBLE_PROTECT_FLAG_SELECT   3'h1
`define WPQ_READ_BIT      1'h1
`define WPQ_PRE_MSB       7
`define WPQ_PRE_LSB       4
`define WPQ_SEL_MSB       3
`define WPQ_SEL_LSB       1
`define WPQ_RW_BIT        0
`define WPQ_BIT_COUNT     4'h8
`define WPQ_SETTLE_COUNT  2'h2

`endif

// ==== verilog/wpq_sync.v ====
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for pin levels
module wpq_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk_sys,
   input  wire             reset,
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] pin_sync
);

   reg [WIDTH-1:0] stage_one;

   // First stage only feeds second
   always @(posedge clk_sys) begin
      if (reset) begin
         stage_one <= {WIDTH{1'b1}};
         pin_sync  <= {WIDTH{1'b1}};
      end else begin
         stage_one <= pin_in;
         pin_sync  <= stage_one;
      end
   end

endmodule

`default_nettype wire

// ==== dv/wpq_status_query_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module wpq_status_query_monitor (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_oe_n,
   input wire logic permanent_protect_flag,
   input wire logic reversible_protect_flag,
   input wire logic lower_half_protect
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_both_nack: assert property (
      permanent_protect_flag && reversible_protect_flag |-> sda_oe_n)
      else $error("ack with both flags set");
   a_ack_scl: assert property ($fell(sda_oe_n) |-> !scl_in)
      else $error("ack begun with bus clock high");
   a_ack_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3])
      else $error("ack too short");
   a_ack_end: assert property ($fell(sda_oe_n) |-> ##[4:40] sda_oe_n)
      else $error("ack never released");
   a_prot_set: assert property ((permanent_protect_flag || reversible_protect_flag) [*4]
      |-> lower_half_protect)
      else $error("lower half not protected");
   c_ack: cover property ($fell(sda_oe_n));
   c_both: cover property (permanent_protect_flag && reversible_protect_flag && sda_oe_n);
   c_perm: cover property (permanent_protect_flag && lower_half_protect);
   c_rev: cover property (reversible_protect_flag && lower_half_protect);
endmodule
`default_nettype wire

// ==== dv/wpq_master.sv ====
`timescale 1ns/100ps
`default_nettype none
module wpq_master (
   input wire logic clk_sys,
   input wire logic sda_line,
   output logic     scl,
   output logic     sda_rel
);
   // Bus idles released, clock stands high
   initial begin
      scl = 1'h1;
      sda_rel = 1'h1;
   end
   task automatic st(input logic c, input logic d, input int n);
      scl = c;
      sda_rel = d;
      repeat (n) @(negedge clk_sys);
   endtask
   // Start, byte msb first, ack slot, stop
   task automatic query(input logic [7:0] b, output logic ack);
      st(1'h1, 1'h0, 8);
      for (int i = 7; i >= 0; i--) begin
         st(1'h0, sda_rel, 4);
         st(1'h0, b[i], 4);
         st(1'h1, b[i], 8);
      end
      st(1'h0, b[0], 4);
      st(1'h0, 1'h1, 4);
      st(1'h1, 1'h1, 4);
      ack = !sda_line;
      st(1'h1, 1'h1, 4);
      st(1'h0, 1'h1, 4);
      st(1'h0, 1'h0, 8);
      st(1'h1, 1'h0, 4);
      st(1'h1, 1'h1, 8);
   endtask
endmodule
`default_nettype wire

// ==== dv/wpq_status_query_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module wpq_status_query_tb;
   logic       clk_sys, reset, perm, rev, prot, revo, sda_oe_n, scl, sda_rel;
   logic [2:0] pins;
   int         fails, checks_done, cycles;
   wire logic  sda_line = sda_rel & sda_oe_n;
   wpq_status_query uut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line),
      .sda_oe_n(sda_oe_n), .chip_select_pin_0(pins[0]), .chip_select_pin_1(pins[1]),
      .chip_select_pin_2(pins[2]), .permanent_protect_flag(perm),
      .reversible_protect_flag(rev), .lower_half_protect(prot), .lower_half_reversible(revo));
   wpq_master m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
   task automatic chk(input logic s, input logic e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: got %b want %b", $time, s, e);
      end
   endtask
   task automatic q(input logic [7:0] b, input logic e);
      logic a;
      m.query(b, a);
      chk(a, e);
   endtask
   // Permanent query at every pin level, then flag set
   task automatic t_perm;
      chk(prot, 1'h0);
      for (int p = 0; p < 8; p++) begin
         pins = p[2:0];
         q({4'h6, p[2:0], 1'h1}, 1'h1);
         q({4'h6, ~p[2:0], 1'h1}, 1'h0);
      end
      perm = 1'h1;
      q(8'h6f, 1'h0);
      chk(prot, 1'h1);
      chk(revo, 1'h0);
      perm = 1'h0;
      $display("t_perm done");
   endtask
   // Both flags set, then reset mid-run with flags clear
   task automatic t_reset;
      pins = 3'h0;
      perm = 1'h1;
      rev = 1'h1;
      q(8'h61, 1'h0);
      q(8'h63, 1'h0);
      chk(prot, 1'h1);
      chk(revo, 1'h0);
      reset = 1'h1;
      {perm, rev} = 2'h0;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(prot, 1'h0);
      chk(sda_oe_n, 1'h1);
      reset = 1'h0;
      repeat (2) @(negedge clk_sys);
      chk(prot, 1'h0);
      chk(revo, 1'h0);
      repeat (2) @(negedge clk_sys);
      $display("t_reset done");
   endtask
   // Reversible query, write bit, flag set, pins refused
   task automatic t_rev;
      pins = 3'h0;
      q(8'h63, 1'h1);
      q(8'h62, 1'h0);
      rev = 1'h1;
      q(8'h63, 1'h0);
      q(8'h61, 1'h1);
      chk(prot, 1'h1);
      chk(revo, 1'h1);
      pins = 3'h1;
      q(8'h63, 1'h1);
      rev = 1'h0;
      pins = 3'h4;
      q(8'h63, 1'h0);
      pins = 3'h2;
      q(8'h63, 1'h0);
      $display("t_rev done");
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      reset = 1'h1;
      {perm, rev, pins} = 5'h00;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'h0;
      repeat (3) @(negedge clk_sys);
      t_perm();
      t_reset();
      t_rev();
      give_verdict();
   end
endmodule
bind wpq_status_query wpq_status_query_monitor mon (.clk_sys(clk_sys), .reset(reset),
   .scl_in(scl_in), .sda_oe_n(sda_oe_n), .permanent_protect_flag(permanent_protect_flag),
   .reversible_protect_flag(reversible_protect_flag), .lower_half_protect(lower_half_protect));
`default_nettype wire
